// >>> shared/isl_defs.svh
// register indices, field positions, reset values and counts of the synth loop control
`ifndef ISL_DEFS_SVH
`define ISL_DEFS_SVH

`define ISL_IDX_UPDATE     10'h005
`define ISL_IDX_CTRL       10'h200
`define ISL_IDX_REFDIV     10'h201
`define ISL_IDX_STATUS     10'h202
`define ISL_IDX_FB         10'h203
`define ISL_IDX_PD         10'h204
`define ISL_IDX_CHDIV      10'h210
`define ISL_CHDIV_SEL_W    2

`define ISL_BIT_UPDATE     0
`define ISL_BIT_CAL        1

`define ISL_CTRL_RST       8'h00
`define ISL_REFDIV_RST     4'h0
`define ISL_FB_RST         8'h14
`define ISL_FB_MIN         8'h0d
`define ISL_PD_RST         4'h3
`define ISL_PD_MIN         4'h3
`define ISL_PD_MAX         4'hb
`define ISL_PD_RESET_CODE  4'hf
`define ISL_CHDIV_RST      8'h00
`define ISL_PFD_MAX_MHZ    125

`define ISL_CAL_PFD_CYCLES 800000
`define ISL_CAL_STEPS      6
`define ISL_BAND_START     6'h20
`define ISL_CP_SHIFT       2
`define ISL_BOOT_SYNC      2'h2

`endif

// >>> shared/isl_pkg.sv
// types shared by the synth loop control
package isl_pkg;
  typedef logic [7:0] isl_byte_t;
  typedef logic [3:0] isl_nib_t;
  typedef logic [5:0] isl_band_t;
  typedef enum logic [1:0] {isl_cal_idle, isl_cal_wait_ref, isl_cal_run} isl_cal_state_t;
endpackage : isl_pkg

// >>> src/isl_ctrl.sv
// integer-N synth loop control: apb registers, divider commit, cp select, vco calibration
`timescale 1ns/1ps
`include "isl_defs.svh"

// Operation
// - reference predivider ratio 1 to 16 sets comparison clock.
// - feedback count is eight bits, usable 13 to 255.
// - post-divider ratio 3 to 11 in four bits.
// - each channel divider divides by 1 to 256.
// - twelve outputs in four groups, one channel divider per group.
// - charge-pump current follows the feedback count for constant bandwidth.
// - power-up calibration only with profile strap, else manual calibrate bit.
// - calibration waits for a valid reference, indefinitely if needed.
// - calibration lasts about 800,000 comparison clock cycles.
// - calibration chooses one of 64 vco bands.
// - calibration resets the post-divider by itself.
module isl_ctrl #(
  parameter int CAL_PFD_CYCLES = `ISL_CAL_PFD_CYCLES
) (
  input  wire logic              pclk,          // apb clock, 20 MHz
  input  wire logic              presetn,       // async reset
  input  wire logic              psel,          // apb select
  input  wire logic              penable,       // apb access phase
  input  wire logic              pwrite,        // apb direction
  input  wire logic [11:0]       paddr,         // apb byte address
  input  wire logic [31:0]       pwdata,        // apb write data
  output logic      [31:0]       prdata,        // apb read data
  output logic                   pready,        // apb ready
  output logic                   pslverr,       // unmapped access
  input  wire logic              ref_valid_i,   // reference validated, async
  input  wire logic              pfd_toggle_i,  // toggles once per comparison cycle
  input  wire logic              vco_above_i,   // vco above target in trial band
  input  wire logic              cal_profile_i, // strap: profile holds calibration
  output isl_pkg::isl_nib_t      ref_div_o,     // predivider ratio minus one
  output isl_pkg::isl_byte_t     fb_count_o,    // feedback count
  output isl_pkg::isl_nib_t      post_div_o,    // post-divider ratio
  output logic                   post_div_rst_o,// post-divider held reset
  output isl_pkg::isl_byte_t     ch_div_a_o,    // group a ratio minus one
  output isl_pkg::isl_byte_t     ch_div_b_o,    // group b ratio minus one
  output isl_pkg::isl_byte_t     ch_div_c_o,    // group c ratio minus one
  output isl_pkg::isl_byte_t     ch_div_d_o,    // group d ratio minus one
  output isl_pkg::isl_byte_t     cp_current_o,  // charge-pump current code
  output isl_pkg::isl_band_t     vco_band_o,    // chosen vco band
  output logic                   cal_busy_o     // calibration in progress
);
  import isl_pkg::*;

  localparam int STEP_TICKS = CAL_PFD_CYCLES / `ISL_CAL_STEPS;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_chdiv(input logic [9:0] idx);
    return idx[9:`ISL_CHDIV_SEL_W] == 8'(`ISL_IDX_CHDIV >> `ISL_CHDIV_SEL_W);
  endfunction : is_chdiv

  // bandwidth stays flat when current rises with the count
  function automatic isl_byte_t cp_code(input isl_byte_t n);
    return n >> `ISL_CP_SHIFT;
  endfunction : cp_code

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic [9:0]     idx;
  logic           acc;
  logic           wr_en;
  logic           mapped;
  isl_byte_t      ctrl_pend_r;
  isl_nib_t       refdiv_pend_r;
  isl_byte_t      fb_pend_r;
  isl_nib_t       pd_pend_r;
  isl_byte_t      ch_pend_r [4];
  isl_byte_t      ch_act_r  [4];
  logic           cal_act_r;
  logic           commit_r;
  isl_byte_t      rd_byte;
  isl_cal_state_t state_r;
  isl_cal_state_t state_nxt;
  isl_band_t      band_r;

  assign idx    = paddr[11:2];
  assign acc    = psel && penable && pready;
  assign wr_en  = acc && pwrite;
  assign mapped = is_chdiv(idx) || idx == `ISL_IDX_UPDATE || idx == `ISL_IDX_CTRL ||
                  idx == `ISL_IDX_REFDIV || idx == `ISL_IDX_STATUS ||
                  idx == `ISL_IDX_FB || idx == `ISL_IDX_PD;

  always_comb begin
    rd_byte = 8'h00;
    if (is_chdiv(idx)) begin
      rd_byte = ch_pend_r[idx[`ISL_CHDIV_SEL_W-1:0]];
    end else begin
      case (idx)
        `ISL_IDX_CTRL:   rd_byte = ctrl_pend_r;
        `ISL_IDX_REFDIV: rd_byte = {4'h0, refdiv_pend_r};
        `ISL_IDX_STATUS: rd_byte = {band_r, state_r == isl_cal_wait_ref,
                                    state_r != isl_cal_idle};
        `ISL_IDX_FB:     rd_byte = fb_pend_r;
        `ISL_IDX_PD:     rd_byte = {4'h0, pd_pend_r};
        default:         rd_byte = 8'h00;
      endcase
    end
  end

  // one wait state: ready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      prdata  <= (psel && penable && !pready && !pwrite) ? {24'h0, rd_byte} : 32'h0;
      pslverr <= psel && penable && !pready && !mapped;
    end
  end

  // pending copies; nothing reaches the loop before the update strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_pend_r   <= `ISL_CTRL_RST;
      refdiv_pend_r <= `ISL_REFDIV_RST;
      fb_pend_r     <= `ISL_FB_RST;
      pd_pend_r     <= `ISL_PD_RST;
      commit_r      <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        ch_pend_r[i] <= `ISL_CHDIV_RST;
      end
    end else begin
      commit_r <= wr_en && idx == `ISL_IDX_UPDATE && pwdata[`ISL_BIT_UPDATE];
      if (wr_en && is_chdiv(idx)) begin
        ch_pend_r[idx[`ISL_CHDIV_SEL_W-1:0]] <= pwdata[7:0];
      end
      if (wr_en) begin
        case (idx)
          `ISL_IDX_CTRL:   ctrl_pend_r   <= pwdata[7:0];
          `ISL_IDX_REFDIV: refdiv_pend_r <= pwdata[3:0];
          `ISL_IDX_FB:     fb_pend_r     <= pwdata[7:0];
          `ISL_IDX_PD:     pd_pend_r     <= pwdata[3:0];
          default:         ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // commit to the loop
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_div_o  <= `ISL_REFDIV_RST;
      fb_count_o <= `ISL_FB_RST;
      post_div_o <= `ISL_PD_RST;
      cal_act_r  <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        ch_act_r[i] <= `ISL_CHDIV_RST;
      end
    end else if (commit_r) begin
      ref_div_o  <= refdiv_pend_r;
      cal_act_r  <= ctrl_pend_r[`ISL_BIT_CAL];
      // counts below the usable floor are lifted to it
      fb_count_o <= (fb_pend_r < `ISL_FB_MIN) ? `ISL_FB_MIN : fb_pend_r;
      if (pd_pend_r == `ISL_PD_RESET_CODE) begin
        post_div_o <= `ISL_PD_RESET_CODE;
      end else if (pd_pend_r < `ISL_PD_MIN) begin
        post_div_o <= `ISL_PD_MIN;
      end else if (pd_pend_r > `ISL_PD_MAX) begin
        post_div_o <= `ISL_PD_MAX;
      end else begin
        post_div_o <= pd_pend_r;
      end
      for (int i = 0; i < 4; i++) begin
        ch_act_r[i] <= ch_pend_r[i];
      end
    end
  end

  // four groups, each with its own divider
  assign ch_div_a_o = ch_act_r[0];
  assign ch_div_b_o = ch_act_r[1];
  assign ch_div_c_o = ch_act_r[2];
  assign ch_div_d_o = ch_act_r[3];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cp_current_o <= 8'h00;
    end else begin
      cp_current_o <= cp_code(fb_count_o);
    end
  end

  // ----------------------------------------------------------------
  // synchronisers and power-up strap
  // ----------------------------------------------------------------
  logic [1:0] ref_sync_r;
  logic [1:0] above_sync_r;
  logic [1:0] strap_sync_r;
  logic [2:0] pfd_sync_r;
  logic [1:0] boot_r;
  logic       pfd_tick;
  logic       auto_start;
  logic       man_start;

  // pfd toggle must be slow enough for pclk; a prescaled copy is expected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_sync_r   <= 2'h0;
      above_sync_r <= 2'h0;
      strap_sync_r <= 2'h0;
      pfd_sync_r   <= 3'h0;
      boot_r       <= 2'h0;
    end else begin
      ref_sync_r   <= {ref_sync_r[0], ref_valid_i};
      above_sync_r <= {above_sync_r[0], vco_above_i};
      strap_sync_r <= {strap_sync_r[0], cal_profile_i};
      pfd_sync_r   <= {pfd_sync_r[1:0], pfd_toggle_i};
      if (boot_r != `ISL_BOOT_SYNC + 2'h1) begin
        boot_r <= boot_r + 2'h1;
      end
    end
  end

  assign pfd_tick   = pfd_sync_r[2] ^ pfd_sync_r[1];
  // strap sampled once, after it has crossed the synchroniser
  assign auto_start = boot_r == `ISL_BOOT_SYNC && strap_sync_r[1];
  assign man_start  = commit_r && ctrl_pend_r[`ISL_BIT_CAL] && !cal_act_r;

  // ----------------------------------------------------------------
  // vco calibration: successive approximation over 64 bands
  // ----------------------------------------------------------------
  logic [19:0] tick_cnt_r;
  logic [2:0]  bit_idx_r;
  logic        step_end;

  assign step_end = state_r == isl_cal_run && pfd_tick &&
                    tick_cnt_r == 20'(STEP_TICKS - 1);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      isl_cal_idle:     if (auto_start || man_start) state_nxt = isl_cal_wait_ref;
      isl_cal_wait_ref: if (ref_sync_r[1]) state_nxt = isl_cal_run;
      isl_cal_run: begin
        if (!ref_sync_r[1]) begin
          state_nxt = isl_cal_wait_ref;
        end else if (step_end && bit_idx_r == 3'h0) begin
          state_nxt = isl_cal_idle;
        end
      end
      default:          state_nxt = isl_cal_idle;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= isl_cal_idle;
      cal_busy_o <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      cal_busy_o <= state_nxt != isl_cal_idle;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= 20'h0;
      bit_idx_r  <= 3'h5;
      band_r     <= `ISL_BAND_START;
    end else if (state_r != isl_cal_run) begin
      tick_cnt_r <= 20'h0;
      bit_idx_r  <= 3'h5;
      band_r     <= (state_nxt == isl_cal_run) ? `ISL_BAND_START : band_r;
    end else if (pfd_tick) begin
      tick_cnt_r <= step_end ? 20'h0 : tick_cnt_r + 20'h1;
      if (step_end) begin
        band_r[bit_idx_r] <= !above_sync_r[1];
        if (bit_idx_r != 3'h0) begin
          band_r[bit_idx_r - 3'h1] <= 1'b1;
          bit_idx_r                <= bit_idx_r - 3'h1;
        end
      end
    end
  end

  // band reaches the vco only once the search ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vco_band_o     <= `ISL_BAND_START;
      post_div_rst_o <= 1'b1;
    end else begin
      if (state_r == isl_cal_run && state_nxt == isl_cal_idle) begin
        vco_band_o <= {band_r[5:1], !above_sync_r[1]};
      end
      post_div_rst_o <= (state_nxt != isl_cal_idle) ||
                        (post_div_o == `ISL_PD_RESET_CODE);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_fb_floor: assert property (@(posedge pclk) disable iff (!presetn)
    fb_count_o >= `ISL_FB_MIN) else $error("feedback count below floor");
  a_pd_legal: assert property (@(posedge pclk) disable iff (!presetn)
    (post_div_o >= `ISL_PD_MIN && post_div_o <= `ISL_PD_MAX) ||
    post_div_o == `ISL_PD_RESET_CODE) else $error("post-divider out of range");
  a_commit_only: assert property (@(posedge pclk) disable iff (!presetn)
    !commit_r |=> $stable(fb_count_o) && $stable(ref_div_o) && $stable(ch_div_a_o))
    else $error("setting moved without update");
  a_commit_take: assert property (@(posedge pclk) disable iff (!presetn)
    commit_r |=> ch_div_d_o == $past(ch_pend_r[3]) && ref_div_o == $past(refdiv_pend_r))
    else $error("update did not apply pending values");
  a_cp_follow: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) |-> cp_current_o == cp_code($past(fb_count_o)))
    else $error("cp current stale");
  a_cal_waits: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == isl_cal_wait_ref && !ref_sync_r[1] |=> cal_busy_o && state_r != isl_cal_run)
    else $error("calibration ran without reference");
  a_cal_launch: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == isl_cal_idle && (auto_start || man_start) |=> cal_busy_o [*2])
    else $error("calibration request lost");
  a_pd_reset: assert property (@(posedge pclk) disable iff (!presetn)
    cal_busy_o |-> post_div_rst_o) else $error("post-divider not reset in calibration");
  a_busy_fall: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(cal_busy_o) |-> $past(state_r) == isl_cal_run && $past(bit_idx_r) == 3'h0)
    else $error("busy fell before band chosen");
endmodule : isl_ctrl

// >>> test/isl_ref_model.sv
// reference source model for the synth loop control bench
`timescale 1ns/1ps

module isl_ref_model (
  input  wire logic pclk,       // bench clock
  input  wire logic presetn,    // async reset
  input  wire logic ref_en,     // reference present at the input
  input  wire logic above_en,   // vco compares above target
  output logic      ref_valid,  // reference validated
  output logic      pfd_toggle, // one edge per comparison cycle
  output logic      vco_above   // band compare result
);
  logic [2:0] div_r;

  assign ref_valid = ref_en;
  assign vco_above = above_en;

  // ----------------------------------------
  // comparison clock
  // ----------------------------------------
  // one tick per five pclk, slower than pclk/4; no ticks without a reference
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r      <= 3'h0;
      pfd_toggle <= 1'b0;
    end else if (ref_en) begin
      div_r <= (div_r == 3'h4) ? 3'h0 : div_r + 3'h1;
      if (div_r == 3'h4) begin
        pfd_toggle <= ~pfd_toggle;
      end
    end
  end
endmodule : isl_ref_model

// >>> test/test_integer_synth_loop_ctrl.sv
// self-checking bench for the synth loop control
`timescale 1ns/1ps
`include "isl_defs.svh"

module test_integer_synth_loop_ctrl;
  import isl_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        ref_en, above_en, ref_valid, pfd_toggle, vco_above, cal_profile;
  logic        post_div_rst, cal_busy;
  isl_nib_t    ref_div, post_div;
  isl_byte_t   fb, cha, chb, chc, chd, cp, exp_fb;
  isl_band_t   band;
  isl_byte_t   ex [5];
  int          error_cnt, samples_checked, seed, i, v, n;

  isl_ctrl #(.CAL_PFD_CYCLES(60)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ref_valid_i(ref_valid), .pfd_toggle_i(pfd_toggle), .vco_above_i(vco_above),
    .cal_profile_i(cal_profile), .ref_div_o(ref_div), .fb_count_o(fb),
    .post_div_o(post_div), .post_div_rst_o(post_div_rst), .ch_div_a_o(cha),
    .ch_div_b_o(chb), .ch_div_c_o(chc), .ch_div_d_o(chd), .cp_current_o(cp),
    .vco_band_o(band), .cal_busy_o(cal_busy));

  isl_ref_model ref_u (.pclk(pclk), .presetn(presetn), .ref_en(ref_en),
    .above_en(above_en), .ref_valid(ref_valid), .pfd_toggle(pfd_toggle),
    .vco_above(vco_above));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic end_sim;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  // one setup cycle, then hold until pready is seen at an edge
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle limit here: a missing pready is left to the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // commit, then let divider and cp outputs settle
  task automatic upd;
    apb(1'b1, `ISL_IDX_UPDATE, 8'h01);
    repeat (4) @(posedge pclk);
    #1;
  endtask : upd

  task automatic wait_busy(input logic val);
    n = 0;
    while (cal_busy !== val && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    #1;
    chk_bit(cal_busy, val);
  endtask : wait_busy

  function automatic isl_byte_t fb_exp(input isl_byte_t x);
    return (x < 8'h0d) ? 8'h0d : x;
  endfunction : fb_exp

  function automatic isl_nib_t pd_exp(input isl_nib_t x);
    if (x == 4'hf) return x;
    return (x < 4'h3) ? 4'h3 : ((x > 4'hb) ? 4'hb : x);
  endfunction : pd_exp

  initial begin
    #2000000;
    error_cnt++;
    end_sim;
  end

  initial begin
    seed = 32'h0b2a;
    error_cnt = 0;
    samples_checked = 0;
    {presetn, psel, penable, pwrite, ref_en, above_en, cal_profile} = 7'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk(fb, 8'h14);
    chk({4'h0, post_div}, 8'h03);
    chk({2'b00, band}, 8'h20);
    exp_fb = 8'h14;
    for (i = 0; i < 10; i++) begin
      v = (i == 0) ? 12 : (i == 1) ? 13 : (i == 2) ? 255 : ($random(seed) & 255);
      apb(1'b1, `ISL_IDX_FB, v[7:0]);
      chk(fb, exp_fb);
      apb(1'b0, `ISL_IDX_FB, 8'h00);
      chk(rd[7:0], v[7:0]);
      upd;
      exp_fb = fb_exp(v[7:0]);
      chk(fb, exp_fb);
      chk(cp, exp_fb >> 2);
    end
    for (i = 10; i < 26; i++) begin
      apb(1'b1, `ISL_IDX_PD, 8'(i % 16));
      upd;
      chk({4'h0, post_div}, {4'h0, pd_exp(4'(i % 16))});
      chk_bit(post_div_rst, (i % 16) == 15);
    end
    for (i = 0; i < 5; i++) begin
      ex[i] = (i == 1) ? 8'hff : 8'($random(seed));
      if (i == 0) ex[i] = ex[i] & 8'h0f;
      apb(1'b1, (i == 0) ? `ISL_IDX_REFDIV : `ISL_IDX_CHDIV + 10'(i - 1), ex[i]);
    end
    upd;
    chk({4'h0, ref_div}, ex[0]);
    chk(cha, ex[1]);
    chk(chb, ex[2]);
    chk(chc, ex[3]);
    chk(chd, ex[4]);
    apb(1'b1, 10'h3ff, 8'h55);
    chk_bit(err, 1'b1);
    apb(1'b0, 10'h3ff, 8'h00);
    chk(rd[7:0], 8'h00);
    chk_bit(cal_busy, 1'b0);
    apb(1'b1, `ISL_IDX_CTRL, 8'h00);
    upd;
    apb(1'b1, `ISL_IDX_CTRL, 8'h02);
    upd;
    chk_bit(cal_busy, 1'b1);
    repeat (300) @(posedge pclk);
    #1;
    chk_bit(cal_busy, 1'b1);
    chk_bit(post_div_rst, 1'b1);
    apb(1'b0, `ISL_IDX_STATUS, 8'h00);
    chk(rd[7:0], 8'h83);
    @(posedge pclk);
    ref_en <= 1'b1;
    wait_busy(1'b0);
    chk_bit(n > 250 && n < 400, 1'b1);
    chk({2'b00, band}, 8'h3f);
    apb(1'b0, `ISL_IDX_STATUS, 8'h00);
    chk(rd[7:0], 8'hfc);
    chk_bit(post_div_rst, 1'b0);
    @(posedge pclk);
    presetn     <= 1'b0;
    above_en    <= 1'b1;
    cal_profile <= 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    wait_busy(1'b1);
    chk_bit(n <= 6, 1'b1);
    wait_busy(1'b0);
    chk({2'b00, band}, 8'h00);
    end_sim;
  end
endmodule : test_integer_synth_loop_ctrl
